/* File: pkg/seqctl_pkg.sv */
package seqctl_pkg;
	// ==========================================================
	// bus and program store geometry
	localparam int ADDR_W = 6;
	localparam int INSTR_W = 24;
	localparam int DATA_W = 8;
	localparam int AXI_AW = 5;

	// ==========================================================
	// register byte offsets
	localparam logic [AXI_AW-1:0] OFF_CTRL = 5'h00;
	localparam logic [AXI_AW-1:0] OFF_CFG = 5'h04;
	localparam logic [AXI_AW-1:0] OFF_VECTOR = 5'h08;
	localparam logic [AXI_AW-1:0] OFF_PROTECT = 5'h0c;
	localparam logic [AXI_AW-1:0] OFF_STATUS = 5'h10;
	localparam logic [AXI_AW-1:0] OFF_PADDR = 5'h14;
	localparam logic [AXI_AW-1:0] OFF_PDATA = 5'h18;

	// ==========================================================
	// control register bits
	localparam int CTRL_RUN = 0;
	localparam int CTRL_STOP = 1;

	// ==========================================================
	// configuration register fields
	localparam int CFG_IRQ_EN = 0;
	localparam int CFG_IRQ_FALL = 1;
	localparam int CFG_IRQ_VEC = 2;
	localparam int CFG_QUAL_EN = 3;
	localparam int CFG_QUAL_LVL = 4;
	localparam int CFG_EXT_EN = 5;
	localparam int CFG_EXT_LVL = 6;
	localparam int CFG_PAUSE_EN = 7;
	localparam int CFG_PAUSE_LVL = 8;
	localparam int CFG_INH_LO = 9;
	localparam int CFG_INH_HI = 11;
	localparam int CFG_INH_INT_LVL = 12;
	localparam int CFG_INH_EXT_LVL = 13;
	localparam int CFG_XS_EN = 14;
	localparam int CFG_XS_FALL = 15;
	localparam int CFG_W = 16;
	localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;

	// inhibit source selection codes
	localparam logic [2:0] INH_OFF = 3'h0;
	localparam logic [2:0] INH_INT = 3'h1;
	localparam logic [2:0] INH_EXT = 3'h2;
	localparam logic [2:0] INH_AND = 3'h3;
	localparam logic [2:0] INH_OR = 3'h4;

	// ==========================================================
	// instruction word layout
	localparam int OP_LO = 21;
	localparam int OP_HI = 23;
	localparam int I_INH = 20;
	localparam int I_MASK = 19;
	localparam int I_STRB = 18;
	localparam int DEST_LO = 12;
	localparam int DEST_HI = 17;

	typedef enum logic [2:0] {
		OP_NOP = 3'b000,
		OP_JUMP = 3'b001,
		OP_IF_IRQ = 3'b010,
		OP_IF_EXT = 3'b011,
		OP_RETURN = 3'b100,
		OP_HALT = 3'b101
	} op_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_FETCH = 2'b10,
		ST_EXEC = 2'b11
	} seq_state_t;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage

/* File: core/seq_prog_mem.sv */
// ==========================================================
// program store, one write port, registered read
module seq_prog_mem
	import seqctl_pkg::*;
(
	input wire logic aclk, // system clock
	input wire logic wr_en, // write strobe
	input wire logic [ADDR_W-1:0] wr_addr, // write line
	input wire logic [INSTR_W-1:0] wr_data, // write word
	input wire logic [ADDR_W-1:0] rd_addr, // read line
	output logic [INSTR_W-1:0] rd_data_r // read word, one cycle later
);
	logic [INSTR_W-1:0] mem [0:(1<<ADDR_W)-1];

	// no reset on the array: contents are defined by software loading
	always_ff @(posedge aclk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_r <= mem[rd_addr];
	end
endmodule // seq_prog_mem

/* File: core/seq_ext_ctl.sv */
// What this block does
// - irq input disabled, or accepted on rising or falling edge as configured.
// - with irq enabled choose polled or vectored handling; polled is the default.
// - vectored mode jumps to the configured routine entry on an accepted irq.
// - with qualification on, irq is accepted only at the qualifier's asserted level.
// - qualifier is off by default, irq accepted regardless of qualifier level.
// - qualifier asserted level selectable as 1 or 0.
// - external branch input tested only by branch-on-external instructions; jump when asserted.
// - external branch input active-high or active-low by configuration.
// - disabling external branch refused while branch-on-external instructions are loaded.
// - asserted pause holds the data, clock and strobe outputs at their level; data_oe_n_r still follows inhibit.
// - pause active-high or active-low, disabled after reset.
// - effective inhibit tri-states every data line not protected by the mask.
// - inhibit from internal bit, external input, or both ANDed or ORed.
// - each inhibit source level selectable 1 or 0; inhibit disabled after reset.
// - sequencing continues while inhibited; only the drivers change.
// - with external start enabled, run waits for the start edge before executing.
// - external start on rising or falling edge, disabled by default.
// - routine return resumes at the line after the one where irq was seen.
// - irq arriving during a routine stays pending until the routine completes.
// - latched irq is cleared by the run command, before any external start wait.
// - polled branch jumps on pending irq without saving a return address.
module seq_ext_ctl
	import seqctl_pkg::*;
(
	input wire logic aclk, // 50 MHz clock
	input wire logic aresetn, // sync reset, active low
	input wire logic [AXI_AW-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte enables
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [AXI_AW-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic irq_in, // interrupt request
	input wire logic qual_in, // interrupt qualifier
	input wire logic external_branch_input, // external branch condition
	input wire logic pause_in, // pause request
	input wire logic ext_inhibit_in, // external inhibit
	input wire logic ext_start_in, // external start trigger
	output logic [DATA_W-1:0] data_out_r, // pattern data
	output logic [DATA_W-1:0] data_oe_n_r, // per-line enable, low drives
	output logic clk_out_r, // pattern clock
	output logic strobe_out_r // pattern strobe
);
	import seqctl_pkg::*;

	// level match used by the qualifier and pause inputs
	function automatic logic hit(input logic en, input logic lvl, input logic pin);
		return en && (pin == lvl);
	endfunction

	logic [CFG_W-1:0] cfg_r;
	logic [ADDR_W-1:0] vector_r, pc_r, ret_r, paddr_r;
	logic [DATA_W-1:0] protect_r;
	logic [(1<<ADDR_W)-1:0] ext_flag_r;
	logic [AXI_AW-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic aw_have_r, w_have_r;
	logic irq_prev_r, xs_prev_r, irq_pend_r, in_service_r, first_line_r;
	seq_state_t state_r;
	logic [INSTR_W-1:0] instr;
	logic wr_fire, run_cmd, stop_cmd, cfg_refuse, prog_wr;
	logic irq_accept, xs_edge, pause_act, eff_inh, int_hit, ext_hit;
	logic exec_go, take_vec, poll_take, ret_take, ext_take, clear_pend, start_go;
	logic [ADDR_W-1:0] pc_inc, pc_nxt;
	op_t op;

	// ==========================================================
	// register bus: write path
	assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
	assign run_cmd = wr_fire && (awaddr_r == OFF_CTRL) && wdata_r[CTRL_RUN];
	assign stop_cmd = wr_fire && (awaddr_r == OFF_CTRL) && wdata_r[CTRL_STOP];
	// clearing the branch enable while such lines are loaded is refused
	assign cfg_refuse = (awaddr_r == OFF_CFG) && !wdata_r[CFG_EXT_EN] && (|ext_flag_r);
	// the store only changes while the sequencer is idle
	assign prog_wr = wr_fire && (awaddr_r == OFF_PDATA) && (state_r == ST_IDLE);

	// address and data taken in either order, held until the write fires
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_r <= 1'b1;
				awaddr_r <= {s_axi_awaddr[AXI_AW-1:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_r <= 1'b1;
				wdata_r <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (awaddr_r > OFF_PDATA) begin
					s_axi_bresp <= RESP_DECERR;
				end else if (cfg_refuse || ((awaddr_r == OFF_PDATA) && (state_r != ST_IDLE))) begin
					s_axi_bresp <= RESP_SLVERR;
				end else begin
					s_axi_bresp <= RESP_OKAY;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// one-entry holding on each channel makes the ready a plain flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// configuration registers; strobes ignored, full-word writes only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg_r <= CFG_RESET;
			vector_r <= '0;
			protect_r <= '0;
			paddr_r <= '0;
		end else if (wr_fire && (s_axi_wstrb != 4'h0 || 1'b1)) begin
			case (awaddr_r)
				OFF_CFG: begin
					if (!cfg_refuse) begin
						cfg_r <= wdata_r[CFG_W-1:0];
					end
				end
				OFF_VECTOR: vector_r <= wdata_r[ADDR_W-1:0];
				OFF_PROTECT: protect_r <= wdata_r[DATA_W-1:0];
				OFF_PADDR: paddr_r <= wdata_r[ADDR_W-1:0];
				OFF_PDATA: begin
					if (prog_wr) begin
						paddr_r <= paddr_r + 1'b1;
					end
				end
				default: ;
			endcase
		end
	end

	// tracks which lines test the external branch input
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_flag_r <= '0;
		end else if (prog_wr) begin
			ext_flag_r[paddr_r] <= (wdata_r[OP_HI:OP_LO] == OP_IF_EXT);
		end
	end

	// ==========================================================
	// register bus: read path, answer one cycle after arvalid taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				case ({s_axi_araddr[AXI_AW-1:2], 2'b00})
					OFF_CFG: s_axi_rdata <= {16'h0000, cfg_r};
					OFF_VECTOR: s_axi_rdata <= {26'h0000000, vector_r};
					OFF_PROTECT: s_axi_rdata <= {24'h000000, protect_r};
					OFF_STATUS: s_axi_rdata <= {19'h00000, |ext_flag_r, in_service_r, irq_pend_r,
						state_r, 2'b00, pc_r};
					OFF_PADDR: s_axi_rdata <= {26'h0000000, paddr_r};
					OFF_CTRL, OFF_PDATA: s_axi_rdata <= '0;
					default: begin
						s_axi_rdata <= '0;
						s_axi_rresp <= RESP_DECERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// external input conditioning
	assign irq_accept = cfg_r[CFG_IRQ_EN]
		&& (cfg_r[CFG_IRQ_FALL] ? (irq_prev_r && !irq_in) : (!irq_prev_r && irq_in))
		&& (!cfg_r[CFG_QUAL_EN] || hit(1'b1, cfg_r[CFG_QUAL_LVL], qual_in));
	assign xs_edge = cfg_r[CFG_XS_FALL] ? (xs_prev_r && !ext_start_in) : (!xs_prev_r && ext_start_in);
	assign pause_act = hit(cfg_r[CFG_PAUSE_EN], cfg_r[CFG_PAUSE_LVL], pause_in);
	assign int_hit = instr[I_INH] == cfg_r[CFG_INH_INT_LVL];
	assign ext_hit = ext_inhibit_in == cfg_r[CFG_INH_EXT_LVL];

	// effective inhibit from the chosen source combination
	always_comb begin
		case (cfg_r[CFG_INH_HI:CFG_INH_LO])
			INH_INT: eff_inh = int_hit && (state_r == ST_EXEC);
			INH_EXT: eff_inh = ext_hit;
			INH_AND: eff_inh = int_hit && ext_hit && (state_r == ST_EXEC);
			INH_OR: eff_inh = (int_hit && (state_r == ST_EXEC)) || ext_hit;
			default: eff_inh = 1'b0;
		endcase
	end

	// previous input levels for edge detection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_prev_r <= 1'b0;
			xs_prev_r <= 1'b0;
		end else begin
			irq_prev_r <= irq_in;
			xs_prev_r <= ext_start_in;
		end
	end

	// ==========================================================
	// sequencer: fetch then execute, frozen by pause
	assign op = op_t'(instr[OP_HI:OP_LO]);
	assign exec_go = (state_r == ST_EXEC) && !pause_act;
	assign start_go = (state_r == ST_WAIT) && xs_edge;
	assign pc_inc = pc_r + 1'b1;
	// a routine's first line never changes flow
	assign poll_take = !first_line_r && (op == OP_IF_IRQ) && !cfg_r[CFG_IRQ_VEC] && irq_pend_r;
	assign ext_take = !first_line_r && (op == OP_IF_EXT) && cfg_r[CFG_EXT_EN]
		&& (external_branch_input == cfg_r[CFG_EXT_LVL]);
	assign ret_take = !first_line_r && (op == OP_RETURN) && in_service_r;
	assign take_vec = cfg_r[CFG_IRQ_VEC] && irq_pend_r && !in_service_r
		&& !instr[I_MASK] && (op != OP_HALT);
	assign clear_pend = (exec_go && (poll_take || take_vec)) || (state_r == ST_IDLE && run_cmd);

	// next line of the sequence
	always_comb begin
		pc_nxt = pc_inc;
		if (take_vec) begin
			pc_nxt = vector_r;
		end else if (ret_take) begin
			pc_nxt = ret_r;
		end else if (poll_take || ext_take || (!first_line_r && op == OP_JUMP)) begin
			pc_nxt = instr[DEST_HI:DEST_LO];
		end
	end

	// state and program counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
			pc_r <= '0;
		end else if (stop_cmd) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (run_cmd) begin
						pc_r <= '0;
						state_r <= cfg_r[CFG_XS_EN] ? ST_WAIT : ST_FETCH;
					end
				end
				ST_WAIT: begin
					if (start_go) begin
						state_r <= ST_FETCH;
					end
				end
				ST_FETCH: begin
					if (!pause_act) begin
						state_r <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					// inhibit does not stall the sequence
					if (exec_go) begin
						state_r <= (op == OP_HALT && !first_line_r) ? ST_IDLE : ST_FETCH;
						pc_r <= pc_nxt;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// interrupt bookkeeping; a new request wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_pend_r <= 1'b0;
			in_service_r <= 1'b0;
			first_line_r <= 1'b0;
			ret_r <= '0;
		end else begin
			if (irq_accept) begin
				irq_pend_r <= 1'b1;
			end else if (clear_pend) begin
				irq_pend_r <= 1'b0;
			end
			if (state_r == ST_IDLE) begin
				in_service_r <= 1'b0;
				first_line_r <= 1'b0;
			end else if (exec_go) begin
				first_line_r <= take_vec;
				if (take_vec) begin
					ret_r <= pc_inc;
					in_service_r <= 1'b1;
				end else if (ret_take) begin
					in_service_r <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// pattern outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_out_r <= '0;
			clk_out_r <= 1'b0;
			strobe_out_r <= 1'b0;
		end else if (!pause_act) begin
			clk_out_r <= (state_r == ST_EXEC);
			if (state_r == ST_EXEC) begin
				data_out_r <= instr[DATA_W-1:0];
				strobe_out_r <= instr[I_STRB];
			end else begin
				strobe_out_r <= 1'b0;
			end
		end
	end

	// protected lines keep driving under inhibit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			data_oe_n_r <= '0;
		end else begin
			data_oe_n_r <= eff_inh ? ~protect_r : '0;
		end
	end

	seq_prog_mem u_mem (
		.aclk(aclk),
		.wr_en(prog_wr),
		.wr_addr(paddr_r),
		.wr_data(wdata_r[INSTR_W-1:0]),
		.rd_addr(pc_r),
		.rd_data_r(instr)
	);

	// ==========================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	pause_hold_a: assert property (pause_act |=> $stable(data_out_r) && $stable(clk_out_r) && $stable(strobe_out_r))
		else $error("outputs moved during pause");
	ext_keep_a: assert property ($fell(cfg_r[CFG_EXT_EN]) |-> $past(ext_flag_r) == '0)
		else $error("branch enable cleared with tests loaded");
	irq_off_a: assert property ((!cfg_r[CFG_IRQ_EN] && !irq_pend_r) |=> !irq_pend_r)
		else $error("disabled irq latched");
	run_clear_a: assert property ((state_r == ST_IDLE && run_cmd && !irq_accept) |=> !irq_pend_r)
		else $error("pending irq survived start");
	vec_entry_a: assert property ((exec_go && take_vec) |=> pc_r == $past(vector_r) && in_service_r
		&& ret_r == $past(pc_r) + 1'b1)
		else $error("vector entry wrong");
	poll_nosave_a: assert property ((exec_go && poll_take && !take_vec) |=> $stable(ret_r)
		&& pc_r == $past(instr[DEST_HI:DEST_LO]))
		else $error("polled branch wrong");
	start_wait_a: assert property ((state_r == ST_WAIT && !xs_edge && !stop_cmd) |=> state_r == ST_WAIT)
		else $error("started without trigger");
	inh_run_a: assert property ((eff_inh && exec_go && op != OP_HALT && !stop_cmd) |=> state_r == ST_FETCH
		##1 (state_r == ST_EXEC || pause_act || stop_cmd))
		else $error("inhibit stalled sequence");
	qual_gate_a: assert property ((cfg_r[CFG_QUAL_EN] && qual_in != cfg_r[CFG_QUAL_LVL]
		&& !irq_pend_r && !clear_pend) |=> !irq_pend_r)
		else $error("unqualified irq accepted");
	ret_a: assert property ((exec_go && ret_take && !take_vec) |=> pc_r == $past(ret_r) && !in_service_r)
		else $error("return target wrong");

	vec_c: cover property (exec_go && take_vec ##[1:40] exec_go && ret_take);
	poll_c: cover property (exec_go && poll_take);
	xs_c: cover property (start_go);
	pause_c: cover property (pause_act && state_r == ST_EXEC [*3]);
endmodule // seq_ext_ctl

/* File: dv/ext_ctl_model.sv */
// ==========================================================
// far-side test circuitry driving the control inputs
module ext_ctl_model (
	input wire logic aclk, // system clock
	output logic irq_in, // interrupt request
	output logic qual_in, // qualifier level
	output logic external_branch_input, // branch condition
	output logic pause_in, // pause request
	output logic ext_inhibit_in, // external inhibit
	output logic ext_start_in // start trigger
);
	timeunit 1ns;
	timeprecision 1ps;

	// quiet levels until the bench asks for something else
	initial begin
		{irq_in, qual_in, external_branch_input, pause_in, ext_inhibit_in, ext_start_in} = 6'h00;
	end

	// levels move just after an edge, so each gets a whole cycle of setup
	task automatic drive(input logic [5:0] v);
		@(posedge aclk);
		{irq_in, qual_in, external_branch_input, pause_in, ext_inhibit_in, ext_start_in} <= v;
	endtask

	// one level change on the request, held so the edge cannot be missed
	task automatic irq_edge();
		@(posedge aclk);
		irq_in <= ~irq_in;
		repeat (3) @(posedge aclk);
	endtask

	// two-cycle start pulse, wider than the minimum the input needs
	task automatic start_pulse();
		@(posedge aclk);
		ext_start_in <= 1'b1;
		repeat (2) @(posedge aclk);
		ext_start_in <= 1'b0;
	endtask
endmodule // ext_ctl_model

/* File: dv/pattern_sequencer_external_controls_test.sv */
module pattern_sequencer_external_controls_test;
	timeunit 1ns;
	timeprecision 1ps;
	import seqctl_pkg::*;

	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, clk_prev;
	logic awready, wready, bvalid, arready, rvalid, clk_out, strobe_out;
	logic irq_in, qual_in, ext_br, pause_in, ext_inh, ext_start, lvl, inb;
	logic [AXI_AW-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [DATA_W-1:0] data_out, oe_n;
	logic [9:0] snap;
	logic [7:0] exp_q[$];
	int fail_count, tests_run, cyc;
	// irq cases: cfg bits, then {qual level, irq rest level, outcome 0 none 1 polled 2 vectored}
	logic [15:0] icfg[8] = '{16'h0001, 16'h0003, 16'h0003, 16'h0019, 16'h0009, 16'h0000, 16'h0019, 16'h0005};
	logic [3:0] iopt[8] = '{4'h1, 4'h0, 4'h5, 4'h0, 4'h1, 4'h0, 4'h9, 4'h2};
	// inhibit cases: {select, internal level, external level, input, tri-stated}
	logic [6:0] htab[7] = '{7'h27, 7'h24, 7'h21, 7'h4f, 7'h3e, 7'h10, 7'h06};

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	seq_ext_ctl u_seq_ext_ctl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_in(irq_in), .qual_in(qual_in),
		.external_branch_input(ext_br), .pause_in(pause_in), .ext_inhibit_in(ext_inh), .ext_start_in(ext_start),
		.data_out_r(data_out), .data_oe_n_r(oe_n), .clk_out_r(clk_out), .strobe_out_r(strobe_out));

	ext_ctl_model u_ext_ctl_model (.aclk(aclk), .irq_in(irq_in), .qual_in(qual_in), .external_branch_input(ext_br),
		.pause_in(pause_in), .ext_inhibit_in(ext_inh), .ext_start_in(ext_start));

	// ==========================================================
	// compare, report and bus tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// address and data offered together, each dropped once taken
	task automatic wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			// ends once bvalid is seen; the hang guard catches a missing response
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk("bresp", er, bresp);
	endtask

	task automatic rd(input logic [AXI_AW-1:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		chk("rresp", er, rresp);
		if (er == RESP_OKAY) chk("rdata", ed, rdata);
	endtask

	function automatic logic [23:0] ins(input logic [2:0] op, input logic [5:0] dst, input logic [7:0] d);
		return {op, 3'h0, dst, 4'h0, d};
	endfunction

	// expected line data, low byte first, zero bytes skipped
	task automatic expect_seq(input logic [47:0] v);
		for (int i = 0; i < 6; i++) begin
			if (v[8*i+:8] != 8'h00) exp_q.push_back(v[8*i+:8]);
		end
	endtask

	// wait for the stream to run out, then let halt settle back to idle
	task automatic drain();
		int n = 0;
		while (exp_q.size() != 0 && n < 200) begin
			@(posedge aclk);
			n++;
		end
		chk("lines_missing", 32'h0, exp_q.size());
		exp_q.delete();
		repeat (4) @(posedge aclk);
	endtask

	// ==========================================================
	// output watcher: each pattern clock rise carries one line's data
	always @(posedge aclk) begin
		clk_prev <= clk_out;
		if (aresetn && clk_out && !clk_prev) begin
			if (exp_q.size() == 0) chk("extra_line", 32'h0, {24'h0, data_out});
			else chk("data_out", {24'h0, exp_q.pop_front()}, {24'h0, data_out});
		end
	end

	// hang guard, far above the several hundred cycles the run needs
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			summarize();
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, clk_prev} = 7'h00;
		{awaddr, araddr, wdata} = '0;
		{fail_count, tests_run, cyc} = '0;
		void'($urandom(97));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFF_CFG, 32'h0, RESP_OKAY);
		rd(5'h1c, 32'h0, RESP_DECERR);
		wr(OFF_PADDR, 32'h0, RESP_OKAY);
		wr(OFF_PDATA, ins(OP_NOP, 6'h00, 8'h01), RESP_OKAY);
		wr(OFF_PDATA, ins(OP_IF_EXT, 6'h04, 8'h02), RESP_OKAY);
		wr(OFF_PDATA, ins(OP_IF_IRQ, 6'h05, 8'h03), RESP_OKAY);
		wr(OFF_PDATA, ins(OP_HALT, 6'h00, 8'h04), RESP_OKAY);
		wr(OFF_PDATA, ins(OP_HALT, 6'h00, 8'h05), RESP_OKAY);
		wr(OFF_PDATA, ins(OP_HALT, 6'h00, 8'h06), RESP_OKAY);
		wr(OFF_PDATA, ins(OP_RETURN, 6'h00, 8'h07), RESP_OKAY);
		rd(OFF_STATUS, 32'h1000, RESP_OKAY);
		wr(OFF_CFG, 32'h0, RESP_SLVERR);
		rd(OFF_CFG, 32'h0, RESP_OKAY);
		wr(OFF_VECTOR, 32'h5, RESP_OKAY);
		wr(OFF_PROTECT, 32'h0f, RESP_OKAY);
		rd(OFF_PROTECT, 32'h0f, RESP_OKAY);
		// branch on external input, random polarity and level
		repeat (4) begin
			lvl = 1'($urandom_range(1, 0));
			inb = 1'($urandom_range(1, 0));
			u_ext_ctl_model.drive({2'b00, inb, 3'b000});
			wr(OFF_CFG, 32'h20 | (32'(lvl) << 6), RESP_OKAY);
			expect_seq(inb == lvl ? 48'h050201 : 48'h04030201);
			wr(OFF_CTRL, 32'h1, RESP_OKAY);
			drain();
		end
		// request seen before run is dropped by the run itself
		wr(OFF_CFG, 32'h61, RESP_OKAY);
		u_ext_ctl_model.irq_edge();
		expect_seq(48'h04030201);
		wr(OFF_CTRL, 32'h1, RESP_OKAY);
		drain();
		// request edges while the sequencer waits for its start
		for (int i = 0; i < 8; i++) begin
			u_ext_ctl_model.drive({iopt[i][2], iopt[i][3], 4'b0000});
			wr(OFF_CFG, 32'h4060 | 32'(icfg[i]), RESP_OKAY);
			wr(OFF_CTRL, 32'h1, RESP_OKAY);
			u_ext_ctl_model.irq_edge();
			expect_seq(iopt[i][1] ? 48'h040302070601 : iopt[i][0] ? 48'h06030201 : 48'h04030201);
			u_ext_ctl_model.start_pulse();
			drain();
		end
		// pause mid-run freezes data, clock and strobe
		wr(OFF_CFG, 32'h41e0, RESP_OKAY);
		wr(OFF_CTRL, 32'h1, RESP_OKAY);
		expect_seq(48'h04030201);
		u_ext_ctl_model.start_pulse();
		u_ext_ctl_model.drive(6'b000100);
		@(posedge aclk);
		#1 snap = {clk_out, strobe_out, data_out};
		repeat (4) begin
			@(posedge aclk);
			#1 chk("paused_outputs", 32'(snap), 32'({clk_out, strobe_out, data_out}));
		end
		u_ext_ctl_model.drive(6'b000000);
		drain();
		// inhibit sources and polarities against the protect mask
		for (int i = 0; i < 7; i++) begin
			wr(OFF_CFG, 32'h20 | (32'(htab[i][6:4]) << 9) | (32'(htab[i][3]) << 12) | (32'(htab[i][2]) << 13), RESP_OKAY);
			u_ext_ctl_model.drive({4'b0000, htab[i][1], 1'b0});
			repeat (3) @(posedge aclk);
			chk("data_oe_n", htab[i][0] ? 32'hf0 : 32'h00, 32'(oe_n));
		end
		// sequencing carries on while inhibited
		wr(OFF_CFG, 32'h2460, RESP_OKAY);
		u_ext_ctl_model.drive(6'b000010);
		expect_seq(48'h04030201);
		wr(OFF_CTRL, 32'h1, RESP_OKAY);
		drain();
		summarize();
	end
endmodule // pattern_sequencer_external_controls_test
